// *** mpwm_pkg.sv ***
/*
  Shared constants, register map and carrier types of the four-generator
  motor PWM output stage.
  Assumes a single 250 MHz system clock; the instruction cycle is two clocks.
*/
package mpwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: instruction period in clocks, gives half-cycle duty resolution
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned INSTR_PERIOD_NS = 8;
  localparam logic [7:0] TCY_CLKS = 8'(INSTR_PERIOD_NS / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register word offsets
  localparam logic [3:0] OFF_PERIOD = 4'h0;
  localparam logic [3:0] OFF_DUTY0 = 4'h1;
  localparam logic [3:0] OFF_TRIG = 4'h5;
  localparam logic [3:0] OFF_PAIR = 4'h6;
  localparam logic [3:0] OFF_OVR = 4'h7;
  localparam logic [3:0] OFF_DTU = 4'h8;
  localparam logic [3:0] OFF_DTS = 4'h9;
  localparam logic [3:0] OFF_TBC = 4'hA;
  localparam logic [3:0] OFF_SEC = 4'hB;
  localparam logic [3:0] OFF_POL = 4'hC;
  localparam logic [3:0] OFF_STAT = 4'hD;
  localparam logic [3:0] NUM_DUTY = 4'h4;

  // Values after reset
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_OVR = 16'hFF00;
  localparam logic [15:0] RST_PAIR = 16'h00FF;
  localparam logic [15:0] RST_POL = 16'h0003;

  ////////////////////////////////////////////////////////////////////////////
  // Counter modes
  typedef enum logic [1:0] {
    MPWM_FREE = 2'b00,
    MPWM_SINGLE = 2'b01,
    MPWM_UPDN = 2'b10,
    MPWM_UPDN2 = 2'b11
  } mpwm_mode_t;

  // Register layouts
  typedef struct packed {
    logic [7:0] rsvd;
    logic [3:0] post;
    logic [1:0] presc;
    mpwm_mode_t mode;
  } mpwm_tbc_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic override_sync_bit;
    logic [3:0] trig_post;
  } mpwm_sec_t;

  typedef struct packed {
    logic dir;
    logic [14:0] cmp;
  } mpwm_trig_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic [3:0] pmode;
    logic [7:0] pen;
  } mpwm_pair_t;

  typedef struct packed {
    logic [7:0] ovd;
    logic [7:0] outs;
  } mpwm_ovr_t;

  typedef struct packed {
    logic [1:0] b_ps;
    logic [5:0] b_cnt;
    logic [1:0] a_ps;
    logic [5:0] a_cnt;
  } mpwm_dtu_t;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [3:0] hsel;
    logic [3:0] lsel;
  } mpwm_dts_t;

endpackage : mpwm_pkg

// *** mpwm_output_stage.sv ***
/*
  Four-generator motor PWM output stage: time base, duty compare, polarity,
  pairing, manual override, ADC trigger, interrupt pulse and dead time.
  Assumes a plain register port with reads answered one cycle later and
  inputs synchronous to clk_sys.
*/
// Implementation choices: the strobed register port and the address map.
// Function
// - Non-zero duty drives output active at period start
// - Output goes inactive when count equals duty
// - Zero duty keeps output inactive all period
// - Duty above period keeps output active always
// - Polarity bits set active pin level per side
// - Complementary pairs never both active
// - Independent pairs unrestricted, no dead time
// - Duty LSB gives half-cycle edge resolution
// - Override-enable set follows duty, cleared manual
// - Manual state bit set active, cleared inactive
// - Complementary override: high wins, dead time kept
// - Sync bit: override changes only at zero
// - Sync clear: override changes reach pins immediately
// - Trigger when count equals trigger compare
// - Direction bit picks down or up match
// - Trigger postscaler passes one per N matches
// - Double-update mode: interrupt at zero and period
// - Interrupt at wrap, or zero counting down
// - Interrupt postscaler divides those two modes
// - Interrupt flag is a self-clearing pulse
// - Dead time is (count+1) times period times prescale
// - Per-generator unit select for each side
// - Free mode wraps at period, loads buffers
// - Up/down modes rise then fall on prescaled clock
// - Up/down mode loads buffers at zero
// - Double-update mode loads at zero and period
`timescale 1ns/1ps
module mpwm_output_stage (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  output logic [3:0] high_side_out,
  output logic [3:0] low_side_out,
  output logic adc_trigger_out,
  output logic interrupt_flag_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [15:0] period_value;
  logic [15:0] duty_buf [4];
  mpwm_pkg::mpwm_trig_t trigger_compare_reg;
  mpwm_pkg::mpwm_pair_t pair_mode_reg;
  mpwm_pkg::mpwm_ovr_t manual_override_reg;
  mpwm_pkg::mpwm_dtu_t dead_time_units_reg;
  mpwm_pkg::mpwm_dts_t dead_time_select_reg;
  mpwm_pkg::mpwm_tbc_t time_base_control;
  mpwm_pkg::mpwm_sec_t secondary_control_reg;
  logic [1:0] polarity_config;

  wire duty_hit = (addr >= mpwm_pkg::OFF_DUTY0) && (addr < mpwm_pkg::OFF_DUTY0 + mpwm_pkg::NUM_DUTY);
  wire [1:0] duty_idx = 2'(addr - mpwm_pkg::OFF_DUTY0);

  // Register writes; unmapped offsets are ignored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_value <= mpwm_pkg::RST_ZERO;
      duty_buf <= '{default: mpwm_pkg::RST_ZERO};
      trigger_compare_reg <= mpwm_pkg::RST_ZERO;
      pair_mode_reg <= mpwm_pkg::RST_PAIR;
      manual_override_reg <= mpwm_pkg::RST_OVR;
      dead_time_units_reg <= mpwm_pkg::RST_ZERO;
      dead_time_select_reg <= mpwm_pkg::RST_ZERO;
      time_base_control <= mpwm_pkg::RST_ZERO;
      secondary_control_reg <= mpwm_pkg::RST_ZERO;
      polarity_config <= mpwm_pkg::RST_POL[1:0];
    end else if (wr_en) begin
      if (addr == mpwm_pkg::OFF_PERIOD) period_value <= {1'b0, wr_data[14:0]};
      else if (duty_hit) duty_buf[duty_idx] <= wr_data;
      else if (addr == mpwm_pkg::OFF_TRIG) trigger_compare_reg <= wr_data;
      else if (addr == mpwm_pkg::OFF_PAIR) pair_mode_reg <= {4'h0, wr_data[11:0]};
      else if (addr == mpwm_pkg::OFF_OVR) manual_override_reg <= wr_data;
      else if (addr == mpwm_pkg::OFF_DTU) dead_time_units_reg <= wr_data;
      else if (addr == mpwm_pkg::OFF_DTS) dead_time_select_reg <= {8'h00, wr_data[7:0]};
      else if (addr == mpwm_pkg::OFF_TBC) time_base_control <= {8'h00, wr_data[7:0]};
      else if (addr == mpwm_pkg::OFF_SEC) secondary_control_reg <= {11'h000, wr_data[4:0]};
      else if (addr == mpwm_pkg::OFF_POL) polarity_config <= wr_data[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base prescaler: one count step per 1, 4, 16 or 64 instruction cycles
  logic [7:0] pcnt;
  logic [14:0] cnt;
  logic up;
  wire [7:0] step_len = mpwm_pkg::TCY_CLKS << {time_base_control.presc, 1'b0};
  wire tick = (pcnt == step_len - 8'h01);
  wire half = (pcnt >= (step_len >> 1));
  wire [14:0] per = period_value[14:0];
  wire updn = time_base_control.mode[1];

  // Counter next state
  logic [14:0] next_cnt;
  logic next_up;
  always_comb begin
    next_cnt = cnt;
    next_up = up;
    if (!updn) begin
      next_up = 1'b1;
      next_cnt = (cnt >= per) ? 15'h0000 : cnt + 15'h0001;
    end else if (up && cnt >= per) begin
      next_up = 1'b0;
      next_cnt = (cnt == 15'h0000) ? cnt : cnt - 15'h0001;
    end else if (!up && cnt == 15'h0000) begin
      next_up = 1'b1;
      next_cnt = cnt + 15'h0001;
    end else begin
      next_cnt = up ? cnt + 15'h0001 : cnt - 15'h0001;
    end
  end

  // Step the counter only on prescaled ticks
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pcnt <= 8'h00;
      cnt <= 15'h0000;
      up <= 1'b1;
    end else begin
      pcnt <= tick ? 8'h00 : pcnt + 8'h01;
      if (tick) begin
        cnt <= next_cnt;
        up <= next_up;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period events and buffer loads
  wire wrap = tick && !updn && (cnt >= per);
  wire hit_zero = tick && updn && !up && (cnt == 15'h0001);
  wire hit_per = tick && updn && up && (next_cnt == per) && (cnt != per);
  wire dbl = (time_base_control.mode == mpwm_pkg::MPWM_UPDN2);
  wire load = wrap || hit_zero || (dbl && hit_per);
  wire sync_pt = tick && (next_cnt == 15'h0000);

  logic [15:0] duty_act [4];
  mpwm_pkg::mpwm_trig_t trig_act;
  mpwm_pkg::mpwm_ovr_t ov_act;

  // Active copies; override copy follows sync bit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      duty_act <= '{default: mpwm_pkg::RST_ZERO};
      trig_act <= mpwm_pkg::RST_ZERO;
      ov_act <= mpwm_pkg::RST_OVR;
    end else begin
      if (load) begin
        duty_act <= duty_buf;
        trig_act <= trigger_compare_reg;
      end
      if (!secondary_control_reg.override_sync_bit || sync_pt) ov_act <= manual_override_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulse and ADC trigger with postscalers
  logic [3:0] ipc;
  logic [3:0] tpc;
  logic step_q;
  wire irq_ev = wrap || hit_zero;
  wire irq_pass = dbl ? (hit_zero || hit_per) : (irq_ev && ipc == time_base_control.post);
  wire dir_ok = !updn || (trig_act.dir ? !up : up);
  wire match = step_q && (cnt == trig_act.cmp);
  wire trig_ok = match && dir_ok;

  // Postscaler counters restart after each passed event
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ipc <= 4'h0;
      tpc <= 4'h0;
      step_q <= 1'b0;
      interrupt_flag_out <= 1'b0;
      adc_trigger_out <= 1'b0;
    end else begin
      step_q <= tick;
      if (irq_ev && !dbl) ipc <= (ipc == time_base_control.post) ? 4'h0 : ipc + 4'h1;
      if (trig_ok) tpc <= (tpc == secondary_control_reg.trig_post) ? 4'h0 : tpc + 4'h1;
      interrupt_flag_out <= irq_pass;
      adc_trigger_out <= trig_ok && (tpc == secondary_control_reg.trig_post);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty compare, override and dead time per pin
  function automatic logic [10:0] mpwm_dt_len(input logic [5:0] c, input logic [1:0] ps);
    mpwm_dt_len = 11'((11'(c) + 11'h001) << ps) * 11'(mpwm_pkg::TCY_CLKS);
  endfunction : mpwm_dt_len

  wire [10:0] len_a = mpwm_dt_len(dead_time_units_reg.a_cnt, dead_time_units_reg.a_ps);
  wire [10:0] len_b = mpwm_dt_len(dead_time_units_reg.b_cnt, dead_time_units_reg.b_ps);
  wire [15:0] pos = {cnt, half};
  wire [15:0] per_full = {per, 1'b1};

  logic [3:0] pwm_act;
  logic [7:0] req;
  logic [7:0] act;
  logic [7:0] lvl;
  logic [10:0] dcnt [8];

  for (genvar g = 0; g < 4; g++) begin : g_gen
    wire indep = pair_mode_reg.pmode[g];
    // Half-resolution compare against count and half bit
    assign pwm_act[g] = (duty_act[g] != 16'h0000) &&
      ((duty_act[g] > per_full) || (pos < duty_act[g]));
    wire h_raw = ov_act.ovd[2*g+1] ? pwm_act[g] : ov_act.outs[2*g+1];
    wire l_pwm = indep ? pwm_act[g] : !pwm_act[g];
    wire l_raw = ov_act.ovd[2*g] ? l_pwm : ov_act.outs[2*g];
    assign req[2*g+1] = pair_mode_reg.pen[2*g+1] && h_raw;
    // High side wins a complementary conflict
    assign req[2*g] = pair_mode_reg.pen[2*g] && l_raw && (indep || !req[2*g+1]);
    for (genvar s = 0; s < 2; s++) begin : g_pin
      localparam int P = 2 * g + s;
      wire sel = s ? dead_time_select_reg.hsel[g] : dead_time_select_reg.lsel[g];
      wire [10:0] need = sel ? len_b : len_a;
      assign lvl[P] = act[P] ^ !polarity_config[s];
      // Activation waits out the dead time; release is immediate
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          dcnt[P] <= 11'h000;
          act[P] <= 1'b0;
        end else if (!req[P]) begin
          dcnt[P] <= 11'h000;
          act[P] <= 1'b0;
        end else if (indep) begin
          act[P] <= 1'b1;
        end else if (!act[P]) begin
          // Full count: partner release is itself one flop late
          if (dcnt[P] >= need) act[P] <= 1'b1;
          else dcnt[P] <= dcnt[P] + 11'h001;
        end
      end
    end
  end

  // Pin drivers, registered after polarity
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      high_side_out <= 4'h0;
      low_side_out <= 4'h0;
    end else begin
      high_side_out <= {lvl[7], lvl[5], lvl[3], lvl[1]};
      low_side_out <= {lvl[6], lvl[4], lvl[2], lvl[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; data valid only in the cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    if (addr == mpwm_pkg::OFF_PERIOD) rd_mux = period_value;
    else if (duty_hit) rd_mux = duty_buf[duty_idx];
    else if (addr == mpwm_pkg::OFF_TRIG) rd_mux = trigger_compare_reg;
    else if (addr == mpwm_pkg::OFF_PAIR) rd_mux = pair_mode_reg;
    else if (addr == mpwm_pkg::OFF_OVR) rd_mux = manual_override_reg;
    else if (addr == mpwm_pkg::OFF_DTU) rd_mux = dead_time_units_reg;
    else if (addr == mpwm_pkg::OFF_DTS) rd_mux = dead_time_select_reg;
    else if (addr == mpwm_pkg::OFF_TBC) rd_mux = time_base_control;
    else if (addr == mpwm_pkg::OFF_SEC) rd_mux = secondary_control_reg;
    else if (addr == mpwm_pkg::OFF_POL) rd_mux = {14'h0000, polarity_config};
    else if (addr == mpwm_pkg::OFF_STAT) rd_mux = {up, cnt};
    else rd_mux = 16'h0000;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rd_data <= 16'h0000;
    else rd_data <= rd_en ? rd_mux : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_free_top;
    tick && !updn && (cnt >= per);
  endsequence

  sequence s_l_rise;
    !pair_mode_reg.pmode[0] && $rose(act[0]);
  endsequence

  a_zero_duty_off: assert property ((duty_act[0] == 16'h0000) |-> !pwm_act[0])
    else $error("zero duty drove output active");
  a_big_duty_on: assert property ((duty_act[0] > per_full) |-> pwm_act[0])
    else $error("duty above period did not hold output active");
  a_pair_exclusive: assert property (!pair_mode_reg.pmode[0] |-> !(act[0] && act[1]))
    else $error("complementary pins both active");
  a_irq_pulse: assert property (interrupt_flag_out |=> !interrupt_flag_out)
    else $error("interrupt flag longer than one cycle");
  a_free_wrap: assert property (s_free_top |=> (cnt == 15'h0000) && $past(load))
    else $error("free counter did not wrap and load");
  a_trig_cause: assert property (adc_trigger_out |-> $past(trig_ok))
    else $error("trigger without compare match");
  a_dead_wait: assert property (s_l_rise |-> $past(req[0], 1) && $past(req[0], 2))
    else $error("low side activated without delay");
  a_sync_hold: assert property ((secondary_control_reg.override_sync_bit && !sync_pt) |=> $stable(ov_act))
    else $error("override changed off the zero point");
  a_pol_pin: assert property (1'b1 |=> high_side_out[0] == ($past(act[1]) ^ !$past(polarity_config[1])))
    else $error("high side level disagrees with polarity");

endmodule : mpwm_output_stage

// *** mpwm_power_stage.sv ***
/*
  Behavioural power-stage gate drivers and ADC trigger input that sit on
  the far side of the motor PWM stage; they tally pin activity per window.
  Assumes pins are active high, registered and sampled on clk_sys; clr zeroes
  every tally at the next edge.
*/
`timescale 1ns/1ps
module mpwm_power_stage (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [3:0] high_side_out,
  input wire logic [3:0] low_side_out,
  input wire logic adc_trigger_out,
  input wire logic interrupt_flag_out,
  output int unsigned n_high,
  output int unsigned n_low,
  output int unsigned n_trig,
  output int unsigned n_irq,
  output int unsigned n_both
);

  ////////////////////////////////////////////////////////////////////////////
  // Gen1 on-time, pulse tallies and shoot-through on any leg
  always @(posedge clk_sys) begin
    if (clr) begin
      n_high <= 0;
      n_low <= 0;
      n_trig <= 0;
      n_irq <= 0;
      n_both <= 0;
    end else begin
      n_high <= n_high + int'(high_side_out[0] === 1'b1);
      n_low <= n_low + int'(low_side_out[0] === 1'b1);
      n_trig <= n_trig + int'(adc_trigger_out === 1'b1);
      n_irq <= n_irq + int'(interrupt_flag_out === 1'b1);
      // Both gates on would short the leg; only legal in independent pairs
      n_both <= n_both + int'((high_side_out & low_side_out) !== 4'h0);
    end
  end

endmodule : mpwm_power_stage

// *** mpwm_output_stage_tb.sv ***
/*
  Self-checking bench for the motor PWM output stage: register access,
  duty, polarity, pairing, dead time, override, trigger and interrupt.
  Assumes the register port of the stage and the tally model beside it.
*/
`timescale 1ns/1ps
module mpwm_output_stage_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic clr = 1'b0;
  logic [15:0] rd_data;
  logic [3:0] high_side_out;
  logic [3:0] low_side_out;
  logic adc_trigger_out;
  logic interrupt_flag_out;
  int unsigned n_high, n_low, n_trig, n_irq, n_both;
  int fails = 0;
  int n_tests = 0;
  logic [15:0] d;
  logic [3:0] offs [4] = '{mpwm_pkg::OFF_PAIR, mpwm_pkg::OFF_OVR, mpwm_pkg::OFF_POL, 4'hE};
  logic [15:0] exps [4] = '{mpwm_pkg::RST_PAIR, mpwm_pkg::RST_OVR, mpwm_pkg::RST_POL, mpwm_pkg::RST_ZERO};

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  mpwm_output_stage uut (
    .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .high_side_out(high_side_out),
    .low_side_out(low_side_out), .adc_trigger_out(adc_trigger_out),
    .interrupt_flag_out(interrupt_flag_out)
  );

  mpwm_power_stage far_side (
    .clk_sys(clk_sys), .clr(clr), .high_side_out(high_side_out), .low_side_out(low_side_out),
    .adc_trigger_out(adc_trigger_out), .interrupt_flag_out(interrupt_flag_out),
    .n_high(n_high), .n_low(n_low), .n_trig(n_trig), .n_irq(n_irq), .n_both(n_both)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks; one idle edge between strobes keeps each drive single
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask : rd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Settle past the buffered loads, then tally n whole edges
  task automatic meas(input int n);
    repeat (300) @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : meas

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, well above the roughly 30 us of planned traffic
  initial begin
    #200_000;
    fails++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; period 7 gives 16 clocks per free-running period
  initial begin
    repeat (6) @(posedge clk_sys);
    chk({22'h00_0000, adc_trigger_out, interrupt_flag_out, high_side_out, low_side_out}, 32'h0000_0000);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(offs[i], d);
      chk({16'h0000, d}, {16'h0000, exps[i]});
    end
    $display("test reset done");
    // Independent pair: no dead time, half-cycle duty steps
    wr(mpwm_pkg::OFF_PERIOD, 16'h0007);
    wr(mpwm_pkg::OFF_PAIR, 16'h01FF);
    wr(mpwm_pkg::OFF_DUTY0, 16'h0008);
    meas(128);
    chk(n_high, 32'h0000_0040);
    chk(n_low, 32'h0000_0040);
    wr(mpwm_pkg::OFF_DUTY0, 16'h0009);
    meas(128);
    chk(n_high, 32'h0000_0048);
    wr(mpwm_pkg::OFF_DUTY0, 16'h0000);
    wr(mpwm_pkg::OFF_POL, 16'h0000);
    meas(128);
    chk(n_high, 32'h0000_0080);
    chk(n_low, 32'h0000_0080);
    wr(mpwm_pkg::OFF_POL, mpwm_pkg::RST_POL);
    $display("test independent done");
    // Complementary: high delayed by unit B (4 clocks), low by unit A (2)
    wr(mpwm_pkg::OFF_PAIR, mpwm_pkg::RST_PAIR);
    wr(mpwm_pkg::OFF_DTU, 16'h4000);
    wr(mpwm_pkg::OFF_DTS, 16'h0010);
    wr(mpwm_pkg::OFF_TRIG, 16'h0003);
    wr(mpwm_pkg::OFF_DUTY0, 16'h0008);
    meas(128);
    chk(n_high, 32'h0000_0020);
    chk(n_low, 32'h0000_0030);
    chk(n_both, 32'h0000_0000);
    chk(n_trig, 32'h0000_0008);
    chk(n_irq, 32'h0000_0008);
    wr(mpwm_pkg::OFF_DUTY0, 16'h0000);
    wr(mpwm_pkg::OFF_SEC, 16'h0003);
    wr(mpwm_pkg::OFF_TBC, 16'h0010);
    meas(128);
    chk(n_high, 32'h0000_0000);
    chk(n_low, 32'h0000_0080);
    chk(n_trig, 32'h0000_0002);
    chk(n_irq, 32'h0000_0004);
    wr(mpwm_pkg::OFF_DUTY0, 16'h0010);
    wr(mpwm_pkg::OFF_SEC, 16'h000F);
    meas(256);
    chk(n_high, 32'h0000_0100);
    chk(n_low, 32'h0000_0000);
    chk(n_trig, 32'h0000_0001);
    $display("test complementary done");
    // Manual override: gen1 both asked on, gen2 low on
    wr(mpwm_pkg::OFF_OVR, 16'h0007);
    meas(16);
    chk({28'h000_0000, high_side_out}, 32'h0000_0001);
    chk({28'h000_0000, low_side_out}, 32'h0000_0002);
    wr(mpwm_pkg::OFF_OVR, 16'h0200);
    meas(16);
    chk({31'h0000_0000, high_side_out[0]}, 32'h0000_0001);
    // Synchronized override, slow counter: 1024 clocks per period
    wr(mpwm_pkg::OFF_OVR, mpwm_pkg::RST_OVR);
    wr(mpwm_pkg::OFF_DUTY0, 16'h0000);
    wr(mpwm_pkg::OFF_SEC, 16'h0010);
    wr(mpwm_pkg::OFF_TBC, 16'h000C);
    // Let one slow wrap load the zero duty first
    repeat (1100) @(posedge clk_sys);
    for (int k = 0; k < 3000; k++) begin
      rd(mpwm_pkg::OFF_STAT, d);
      if (d[14:0] === 15'h0003) break;
    end
    wr(mpwm_pkg::OFF_OVR, 16'h0002);
    repeat (20) @(posedge clk_sys);
    chk({31'h0000_0000, high_side_out[0]}, 32'h0000_0000);
    repeat (1100) @(posedge clk_sys);
    chk({31'h0000_0000, high_side_out[0]}, 32'h0000_0001);
    wr(mpwm_pkg::OFF_SEC, 16'h0000);
    wr(mpwm_pkg::OFF_OVR, 16'h0000);
    repeat (10) @(posedge clk_sys);
    chk({31'h0000_0000, high_side_out[0]}, 32'h0000_0000);
    $display("test override done");
    // Up/down modes: 28 clocks per up-and-down sweep
    wr(mpwm_pkg::OFF_TBC, 16'h0002);
    meas(112);
    chk(n_irq, 32'h0000_0004);
    wr(mpwm_pkg::OFF_TBC, 16'h0013);
    wr(mpwm_pkg::OFF_TRIG, 16'h8003);
    meas(112);
    chk(n_irq, 32'h0000_0008);
    chk(n_trig, 32'h0000_0004);
    $display("test updown done");
    end_sim();
  end

endmodule : mpwm_output_stage_tb
